// ==== hw/exec_alu.v ====
`timescale 1ns/1ps
`include "rsse_defines.vh"

module exec_alu (
  input wire [2:0] op,
  input wire [7:0] f_val,
  input wire [7:0] w_val,
  input wire [7:0] lit,
  input wire c_in,
  output reg [7:0] result,
  output reg c_out,
  output reg dc_out,
  output reg z_out
);

  reg [7:0] diff;

  // Result and flags per opcode
  always @* begin
    diff = lit - w_val;
    result = w_val;
    c_out = c_in;
    dc_out = 1'b0;
    z_out = 1'b0;
    case (op)
      `OP_ROT_LEFT: begin
        result = {f_val[6:0], c_in};
        c_out = f_val[7];
      end
      `OP_ROT_RIGHT: begin
        result = {c_in, f_val[7:1]};
        c_out = f_val[0];
      end
      `OP_SUB_LIT: begin
        result = diff[7:0];
        c_out = (w_val <= lit);
        dc_out = (w_val[3:0] <= lit[3:0]);
        z_out = (diff[7:0] == 8'h00);
      end
      default: begin
        result = w_val;
      end
    endcase
  end

endmodule // exec_alu

// ==== hw/rotate_subtract_sleep_exec.v ====
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "rsse_defines.vh"

module rotate_subtract_sleep_exec #(
  parameter RF_DEPTH = 128,
  parameter WDT_PRE_W = 8
) (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire wake_req,
  output reg osc_halt,
  output reg sleep_status
);

  // Run and sleep states
  localparam ST_RUN = 1'b0;
  localparam ST_SLEEP = 1'b1;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0] rf [0:RF_DEPTH-1];
  reg [31:0] cmd_q;
  reg exec_q;
  reg [7:0] wreg_q;
  reg carry_q;
  reg digit_carry_flag_q;
  reg zero_q;
  reg powerdown_status_n_q;
  reg timeout_status_n_q;
  reg wdt_en_q;
  reg state_q;
  reg state_d;

  // Decode, datapath and watchdog nets
  wire [2:0] op_sel;
  wire dest_sel;
  wire [6:0] faddr;
  wire [7:0] lit;
  wire [7:0] f_val;
  wire [7:0] alu_result;
  wire alu_c;
  wire alu_dc;
  wire alu_z;
  wire [7:0] wdt_count;
  wire [WDT_PRE_W-1:0] wdt_pre;
  wire wdt_overflow;
  wire run_exec;
  wire do_sleep;
  wire wake;
  wire access;
  wire complete;
  wire wr;
  wire wr_cmd;
  wire wr_wreg;
  wire wr_status;
  wire wr_wdt;
  wire wr_rf;
  wire rot_op;
  reg [31:0] rd_val;

  // Command fields and execute qualifiers
  assign op_sel = cmd_q[`CMD_OP_MSB:`CMD_OP_LSB];
  assign dest_sel = cmd_q[`CMD_DEST_BIT];
  assign faddr = cmd_q[`CMD_FADDR_MSB:`CMD_FADDR_LSB];
  assign lit = cmd_q[`CMD_LIT_MSB:`CMD_LIT_LSB];
  assign f_val = rf[faddr];
  assign run_exec = exec_q & (state_q == ST_RUN);
  assign do_sleep = run_exec & (op_sel == `OP_SLEEP);
  assign wake = wake_req | wdt_overflow;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // True for a register-file window address; bit 9 set lies outside, not an alias
  function is_rf;
    input [11:0] a;
    begin
      is_rf = ((a & `OFS_RF_MASK) == `OFS_RF_BASE) && (a[9] == 1'b0);
    end
  endfunction

  // Mapped address check
  function addr_hit;
    input [11:0] a;
    begin
      addr_hit = (a[1:0] == 2'b00) &&
                 ((a == `OFS_CMD) || (a == `OFS_WREG) || (a == `OFS_STATUS) ||
                  (a == `OFS_WDT) || (is_rf(a) && (a[8:2] < RF_DEPTH)));
    end
  endfunction

  // True for either rotate opcode
  function is_rotate;
    input [2:0] o;
    begin
      is_rotate = (o == `OP_ROT_LEFT) || (o == `OP_ROT_RIGHT);
    end
  endfunction

  assign access = psel & penable;
  assign complete = access & pready;
  assign wr = complete & pwrite & addr_hit(paddr);

  // Write strobes, one per target; a write lands only at the completing edge
  assign wr_cmd = wr & (paddr == `OFS_CMD);
  assign wr_wreg = wr & (paddr == `OFS_WREG);
  assign wr_status = wr & (paddr == `OFS_STATUS);
  assign wr_wdt = wr & (paddr == `OFS_WDT);
  assign wr_rf = wr & is_rf(paddr);
  assign rot_op = is_rotate(op_sel);

  // Read mux
  always @* begin
    rd_val = 32'h0000_0000;
    if (is_rf(paddr)) begin
      rd_val = {24'h00_0000, rf[paddr[8:2]]};
    end else begin
      case (paddr)
        `OFS_CMD: rd_val = cmd_q;
        `OFS_WREG: rd_val = {24'h00_0000, wreg_q};
        `OFS_STATUS: begin
          rd_val[`ST_CARRY] = carry_q;
          rd_val[`ST_DIGIT] = digit_carry_flag_q;
          rd_val[`ST_ZERO] = zero_q;
          rd_val[`ST_PD_N] = powerdown_status_n_q;
          rd_val[`ST_TO_N] = timeout_status_n_q;
          rd_val[`ST_SLEEP] = (state_q == ST_SLEEP);
        end
        `OFS_WDT: begin
          rd_val[`WDT_EN_BIT] = wdt_en_q;
          rd_val[`WDT_CNT_LSB+7:`WDT_CNT_LSB] = wdt_count;
          rd_val[`WDT_PRE_LSB+WDT_PRE_W-1:`WDT_PRE_LSB] = wdt_pre;
        end
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // One wait state, registered answer
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      prdata <= addr_hit(paddr) ? rd_val : 32'h0000_0000;
      pslverr <= ~addr_hit(paddr);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  // A command write launches one execute cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_q <= 32'h0000_0000;
      exec_q <= 1'b0;
      wdt_en_q <= 1'b0;
    end else begin
      exec_q <= wr_cmd; // Gated off by run_exec while asleep
      if (wr_cmd) begin
        cmd_q <= pwdata;
      end
      if (wr_wdt) begin
        wdt_en_q <= pwdata[`WDT_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  exec_alu u_alu (
    .op(op_sel),
    .f_val(f_val),
    .w_val(wreg_q),
    .lit(lit),
    .c_in(carry_q),
    .result(alu_result),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z)
  );

  // Register file: software window and rotate write-back
  always @(posedge mclk) begin
    if (wr_rf) begin
      rf[paddr[8:2]] <= pwdata[7:0];
    end
    if (run_exec && dest_sel && rot_op) begin
      rf[faddr] <= alu_result;
    end
  end

  // Working register and flags; hardware update wins over software
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wreg_q <= `RST_WREG;
      {zero_q, digit_carry_flag_q, carry_q} <= `RST_FLAGS;
    end else begin
      if (wr_wreg) begin
        wreg_q <= pwdata[7:0];
      end
      if (wr_status) begin
        carry_q <= pwdata[`ST_CARRY];
        digit_carry_flag_q <= pwdata[`ST_DIGIT];
        zero_q <= pwdata[`ST_ZERO];
      end
      if (run_exec) begin
        case (op_sel)
          `OP_ROT_LEFT, `OP_ROT_RIGHT: begin
            carry_q <= alu_c;
            if (!dest_sel) begin
              wreg_q <= alu_result;
            end
          end
          `OP_SUB_LIT: begin
            wreg_q <= alu_result;
            carry_q <= alu_c;
            digit_carry_flag_q <= alu_dc;
            zero_q <= alu_z;
          end
          default: begin
            carry_q <= carry_q;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sleep and watchdog
  // ----------------------------------------------------------------
  // Sleep empties the watchdog so a full time-out runs again from zero
  watchdog_counter #(
    .PRE_W(WDT_PRE_W),
    .CNT_W(8)
  ) u_wdt (
    .mclk(mclk),
    .rst(rst),
    .enable(wdt_en_q),
    .clear(do_sleep),
    .count_q(wdt_count),
    .pre_q(wdt_pre),
    .overflow_q(wdt_overflow)
  );

  // Run or sleep
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (do_sleep) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // State, halt output and power status bits
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
      osc_halt <= 1'b0;
      sleep_status <= 1'b0;
      powerdown_status_n_q <= `RST_PD_N;
      timeout_status_n_q <= `RST_TO_N;
    end else begin
      state_q <= state_d;
      osc_halt <= (state_d == ST_SLEEP);
      sleep_status <= (state_d == ST_SLEEP);
      if (wdt_overflow) begin
        timeout_status_n_q <= 1'b0;
      end
      // Sleep comes last so its time-out set wins over an overflow
      if (do_sleep) begin
        powerdown_status_n_q <= 1'b0;
        timeout_status_n_q <= 1'b1;
      end
    end
  end

endmodule // rotate_subtract_sleep_exec

// ==== hw/rsse_defines.vh ====
`ifndef RSSE_DEFINES_VH
`define RSSE_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CMD 12'h000
`define OFS_WREG 12'h004
`define OFS_STATUS 12'h008
`define OFS_WDT 12'h00c
`define OFS_RF_BASE 12'h400
`define OFS_RF_MASK 12'hc00

// ----------------------------------------------------------------
// Command fields
// ----------------------------------------------------------------
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_DEST_BIT 3
`define CMD_FADDR_LSB 4
`define CMD_FADDR_MSB 10
`define CMD_LIT_LSB 16
`define CMD_LIT_MSB 23

// Opcodes
`define OP_NONE 3'h0
`define OP_ROT_LEFT 3'h1
`define OP_ROT_RIGHT 3'h2
`define OP_SUB_LIT 3'h3
`define OP_SLEEP 3'h4

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define ST_CARRY 0
`define ST_DIGIT 1
`define ST_ZERO 2
`define ST_PD_N 3
`define ST_TO_N 4
`define ST_SLEEP 8

// Watchdog register fields
`define WDT_EN_BIT 0
`define WDT_CNT_LSB 8
`define WDT_PRE_LSB 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_WREG 8'h00
`define RST_FLAGS 3'h0
`define RST_PD_N 1'b1
`define RST_TO_N 1'b1
`define RST_WDT_CNT 8'h00

`endif

// ==== hw/watchdog_counter.v ====
`timescale 1ns/1ps
`include "rsse_defines.vh"

module watchdog_counter #(
  parameter PRE_W = 8,
  parameter CNT_W = 8
) (
  input wire mclk,
  input wire rst,
  input wire enable,
  input wire clear,
  output reg [CNT_W-1:0] count_q,
  output reg [PRE_W-1:0] pre_q,
  output reg overflow_q
);

  // Prescaler feeds the count; clear empties both
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_q <= {PRE_W{1'b0}};
      count_q <= {CNT_W{1'b0}};
      overflow_q <= 1'b0;
    end else if (clear) begin
      pre_q <= {PRE_W{1'b0}};
      count_q <= {CNT_W{1'b0}};
      overflow_q <= 1'b0;
    end else if (enable) begin
      pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
      overflow_q <= (&pre_q) & (&count_q);
      if (&pre_q) begin
        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end else begin
      overflow_q <= 1'b0;
    end
  end

endmodule // watchdog_counter

// ==== tb/rotate_subtract_sleep_exec_test.sv ====
`timescale 1ns/1ps
`include "rsse_defines.vh"
module rotate_subtract_sleep_exec_test;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wake_req = 0, e, c, d;
  logic [11:0] paddr = 0, fa;
  logic [31:0] pwdata = 0, r = 0;
  logic [7:0] v, x, k, d8;
  logic [2:0] op;
  logic [7:0] wt [5] = '{8'h05, 8'h06, 8'h1f, 8'h21, 8'h00};
  logic [7:0] kt [5] = '{8'h05, 8'h05, 8'h20, 8'h1f, 8'hff};
  wire [31:0] prdata;
  wire pready, pslverr, osc_halt, sleep_status;
  int n_fail = 0, cmp_count = 0;
  // ------------------------------
  // Design, clock and bus tasks
  // ------------------------------
  rotate_subtract_sleep_exec #(.WDT_PRE_W(2)) dut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_req(wake_req), .osc_halt(osc_halt),
    .sleep_status(sleep_status));
  // Clock at 40 MHz
  initial forever #12.5 mclk = ~mclk;
  task report_and_stop;
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] s, input [31:0] y);
    cmp_count++;
    if (s !== y) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, y);
    end
  endtask
  // One APB transfer, held until ready
  task xfer(input w, input [11:0] a, input [31:0] wd);
    int i;
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      n_fail++;
      report_and_stop;
    end
  endtask
  // Bounded wait for a halt level
  task halt_is(input h);
    for (int i = 0; i < 20 && osc_halt !== h; i++) @(posedge mclk);
    chk({31'h0, osc_halt}, {31'h0, h});
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 0;
    xfer(0, `OFS_STATUS, 0);
    chk(r, 32'h18);
    xfer(0, 12'h010, 0);
    chk(r | {31'h0, e}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      op = i[1] ? `OP_ROT_RIGHT : `OP_ROT_LEFT;
      d = i[0];
      c = i[0] ^ i[1];
      v = 8'he6 ^ 8'(i * 103);
      k = i[1] ? 8'd127 : 8'(i * 9);
      fa = `OFS_RF_BASE + {3'h0, k[6:0], 2'h0};
      x = i[1] ? {c, v[7:1]} : {v[6:0], c};
      xfer(1, fa, {24'h0, v});
      xfer(1, `OFS_WREG, 32'h5a);
      xfer(1, `OFS_STATUS, {29'h0, 2'b11, c});
      xfer(1, `OFS_CMD, {21'h0, k[6:0], d, op});
      xfer(0, `OFS_WREG, 0);
      chk(r, d ? 32'h5a : {24'h0, x});
      xfer(0, fa, 0);
      chk(r & 32'hff, {24'h0, d ? x : v});
      xfer(0, `OFS_STATUS, 0);
      chk(r & 32'h7, {29'h0, 2'b11, i[1] ? v[0] : v[7]});
    end
    for (int i = 0; i < 5; i++) begin
      v = wt[i];
      k = kt[i];
      d8 = k - v;
      x = {5'h0, d8 == 8'h0, v[3:0] <= k[3:0], v <= k};
      xfer(1, `OFS_WREG, {24'h0, v});
      xfer(1, `OFS_STATUS, {29'h0, ~x[2:0]});
      xfer(1, `OFS_CMD, {8'h0, k, 13'h0, `OP_SUB_LIT});
      xfer(0, `OFS_WREG, 0);
      chk(r, {24'h0, d8});
      xfer(0, `OFS_STATUS, 0);
      chk(r & 32'h7, {29'h0, x[2:0]});
    end
    xfer(1, `OFS_WDT, 32'h1);
    for (int j = 0; j < 400 && r[4] !== 1'b0; j++) xfer(0, `OFS_STATUS, 0);
    chk({31'h0, r[4]}, 0);
    repeat (40) @(posedge mclk);
    xfer(1, `OFS_WDT, 0);
    xfer(0, `OFS_WDT, 0);
    chk({31'h0, r[23:8] != 16'h0}, 1);
    xfer(1, `OFS_CMD, {29'h0, `OP_SLEEP});
    halt_is(1);
    chk({31'h0, sleep_status}, 1);
    xfer(0, `OFS_WDT, 0);
    chk(r & 32'hffff00, 0);
    xfer(0, `OFS_STATUS, 0);
    chk(r & 32'h118, 32'h110);
    xfer(1, `OFS_WREG, 32'h3c);
    xfer(1, `OFS_CMD, {8'h0, 8'h50, 13'h0, `OP_SUB_LIT});
    wake_req <= 1;
    halt_is(0);
    wake_req <= 0;
    chk({31'h0, sleep_status}, 0);
    xfer(0, `OFS_WREG, 0);
    chk(r, 32'h3c);
    xfer(1, `OFS_WDT, 32'h1);
    xfer(1, `OFS_CMD, {29'h0, `OP_SLEEP});
    halt_is(1);
    for (int j = 0; j < 1100 && osc_halt !== 1'b0; j++) @(posedge mclk);
    chk({31'h0, osc_halt}, 0);
    xfer(0, `OFS_STATUS, 0);
    chk(r & 32'h118, 32'h0);
    report_and_stop;
  end
endmodule // rotate_subtract_sleep_exec_test
bind rotate_subtract_sleep_exec rsse_sva chk_i (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wake_req(wake_req), .osc_halt(osc_halt),
  .sleep_status(sleep_status));

// ==== tb/rsse_sva.sv ====
`timescale 1ns/1ps
`include "rsse_defines.vh"
module rsse_sva (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire wake_req,
  input wire osc_halt,
  input wire sleep_status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ------------------------------
  // Bus answer and sleep control
  // ------------------------------
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_RDY_TIME: assert property (psel && !penable |-> ##2 pready)
    else $error("answer not after one wait");
  AST_RDY_CAUSE: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready without access");
  AST_ERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error reply not clean");
  AST_ERR_MAP: assert property (pready && paddr == 12'h010 |-> pslverr)
    else $error("unmapped address accepted");
  AST_HALT_EQ: assert property (osc_halt == sleep_status)
    else $error("halt and sleep differ");
  AST_HALT_CAUSE: assert property ($rose(osc_halt) |->
    $past(pready && pwrite && paddr == `OFS_CMD && pwdata[2:0] == `OP_SLEEP, 2))
    else $error("halt without sleep");
  AST_WAKE: assert property (osc_halt && wake_req |-> ##[1:3] !osc_halt)
    else $error("no wake");
endmodule // rsse_sva
